// *** verilog/sbe_device_end.sv ***
`timescale 1ns/1ps
`default_nettype none
module sbe_device_end #(
    parameter logic [7:0] CHANNEL_ID = 8'h00,
    parameter int NOTICE_KINDS = sbe_pkg::NOTICE_KINDS,
    parameter bit ALLOW_OEM_OVERSIZE = 1'b1
) (
    input wire logic clk_sys,
    input wire logic reset,
    sbe_link_if.dev link,
    input wire logic [NOTICE_KINDS-1:0] event_req,
    input wire logic sideband_link_active,
    input wire logic init_entry,
    output logic pt_enable,
    output logic in_initial,
    output logic cmd_dropped,
    output logic notice_lost
);
    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    logic init_reg;
    logic [2:0] drain_reg;
    logic [NOTICE_KINDS-1:0] enable_reg;
    logic [7:0] tag_reg;
    logic last_valid_reg;
    logic rsp_valid_reg;
    logic [7:0] rsp_inst_reg;
    logic [7:0] rsp_type_reg;
    logic [15:0] rsp_code_reg;
    logic [15:0] rsp_reason_reg;
    logic [31:0] rsp_data_reg;
    logic notice_valid_reg;
    logic [7:0] notice_tag_reg;
    logic [7:0] notice_type_reg;
    logic dropped_reg;
    logic lost_reg;

    // ------------------------------------------------------------
    // receive checks
    // ------------------------------------------------------------
    wire logic cmd_fire = link.cmd_valid;
    wire logic rsp_busy = rsp_valid_reg & ~link.rsp_ready;
    wire logic oversize_ok = link.cmd_oem & ALLOW_OEM_OVERSIZE;
    wire logic drop_fcs = ~link.cmd_fcs_ok;
    wire logic drop_len = link.cmd_len_short | (link.cmd_len_long & ~oversize_ok);
    wire logic drop_csum = link.cmd_csum_present & ~link.cmd_csum_ok;
    wire logic drop_chan = link.cmd_chan_id != CHANNEL_ID;
    wire logic drop_res = rsp_busy;
    wire logic drop_rev = link.cmd_rev != sbe_pkg::HDR_REV;
    wire logic drop_drain = drain_reg != 3'h0;
    wire logic drop_any = drop_fcs | drop_len | drop_csum | drop_chan | drop_res
        | drop_rev | drop_drain;
    wire logic cmd_drop = cmd_fire & drop_any;
    wire logic cmd_take = cmd_fire & ~drop_any;
    wire logic is_retry = last_valid_reg & (link.cmd_inst_id == rsp_inst_reg);
    wire logic cmd_exec = cmd_take & ~is_retry;
    wire logic is_clear = link.cmd_type == sbe_pkg::CMD_CLEAR_INIT;
    wire logic is_enable = link.cmd_type == sbe_pkg::CMD_NOTICE_ENABLE;
    wire logic is_status = link.cmd_type == sbe_pkg::CMD_GET_STATUS;
    wire logic is_oem = link.cmd_type == sbe_pkg::CMD_OEM;
    wire logic blocked = init_reg & ~is_clear;
    wire logic apply_enable = cmd_exec & is_enable & ~blocked;
    wire logic apply_clear = cmd_exec & is_clear;
    wire logic [31:0] status_word = {init_reg, sideband_link_active,
        {(30-NOTICE_KINDS){1'b0}}, enable_reg};

    assign link.cmd_ready = 1'b1;

    // ------------------------------------------------------------
    // response selection
    // ------------------------------------------------------------
    logic [15:0] new_code;
    logic [15:0] new_reason;
    logic [31:0] new_data;
    always_comb begin
        new_code = sbe_pkg::CODE_OK;
        new_reason = sbe_pkg::REASON_NONE;
        new_data = 32'h00000000;
        if (blocked) begin
            new_code = sbe_pkg::CODE_FAILED;
            new_reason = sbe_pkg::REASON_INIT_REQ;
        end else if (is_status) begin
            new_data = status_word;
        end else if (is_oem) begin
            new_data = link.cmd_data;
        end else if (!is_clear && !is_enable) begin
            new_code = sbe_pkg::CODE_UNSUPPORTED;
            new_reason = sbe_pkg::REASON_UNKNOWN_TYPE;
        end
    end

    // ------------------------------------------------------------
    // initial state and configuration
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            init_reg <= sbe_pkg::INIT_RST;
            drain_reg <= 3'h0;
        end else if (init_entry) begin
            init_reg <= 1'b1;
            drain_reg <= sbe_pkg::DRAIN_CYCLES;
        end else begin
            if (apply_clear) begin
                init_reg <= 1'b0;
            end
            if (drop_drain) begin
                drain_reg <= drain_reg - 3'h1;
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset || init_entry) begin
            enable_reg <= '0;
            tag_reg <= sbe_pkg::TAG_RST;
        end else if (apply_enable) begin
            enable_reg <= link.cmd_data[sbe_pkg::ENABLE_LSB +: NOTICE_KINDS];
            tag_reg <= link.cmd_data[sbe_pkg::TAG_LSB +: 8];
        end
    end

    // ------------------------------------------------------------
    // response register, doubles as the replay copy
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            rsp_valid_reg <= 1'b0;
            last_valid_reg <= 1'b0;
            rsp_inst_reg <= 8'h00;
            rsp_type_reg <= 8'h00;
            rsp_code_reg <= 16'h0000;
            rsp_reason_reg <= 16'h0000;
            rsp_data_reg <= 32'h00000000;
        end else if (cmd_take) begin
            rsp_valid_reg <= 1'b1;
            last_valid_reg <= 1'b1;
            if (!is_retry) begin
                rsp_inst_reg <= link.cmd_inst_id;
                rsp_type_reg <= link.cmd_type | sbe_pkg::RSP_FLAG;
                rsp_code_reg <= new_code;
                rsp_reason_reg <= new_reason;
                rsp_data_reg <= new_data;
            end
        end else if (link.rsp_ready) begin
            rsp_valid_reg <= 1'b0;
        end
    end

    assign link.rsp_valid = rsp_valid_reg;
    assign link.rsp_inst_id = rsp_inst_reg;
    assign link.rsp_chan_id = CHANNEL_ID;
    assign link.rsp_type = rsp_type_reg;
    assign link.rsp_code = rsp_code_reg;
    assign link.rsp_reason = rsp_reason_reg;
    assign link.rsp_data = rsp_data_reg;

    // ------------------------------------------------------------
    // event notices
    // ------------------------------------------------------------
    wire logic notice_gate = sideband_link_active & ~init_reg;
    wire logic [NOTICE_KINDS-1:0] pending = event_req & enable_reg
        & {NOTICE_KINDS{notice_gate}};
    wire logic slot_free = ~notice_valid_reg | link.notice_ready;
    wire logic load_notice = (pending != '0) & slot_free;
    logic [7:0] pick;
    logic [NOTICE_KINDS-1:0] lower;
    logic [NOTICE_KINDS:0] seen;
    assign seen[0] = 1'b0;

    genvar gi;
    generate
        for (gi = 0; gi < NOTICE_KINDS; gi = gi + 1) begin : g_pick
            assign lower[gi] = pending[gi] & ~seen[gi];
            assign seen[gi+1] = seen[gi] | pending[gi];
        end
    endgenerate

    always_comb begin
        pick = 8'h00;
        for (int i = NOTICE_KINDS - 1; i >= 0; i--) begin
            if (lower[i]) begin
                pick = 8'(i);
            end
        end
    end

    // more than one kind at once loses all but the lowest; a busy slot loses them all
    wire logic [NOTICE_KINDS-1:0] others = pending & ~lower;
    wire logic lose = (pending != '0) & (~slot_free | (others != '0));

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            notice_valid_reg <= 1'b0;
            notice_tag_reg <= sbe_pkg::TAG_RST;
            notice_type_reg <= 8'h00;
        end else if (!notice_gate) begin
            notice_valid_reg <= 1'b0;
        end else if (load_notice) begin
            notice_valid_reg <= 1'b1;
            notice_tag_reg <= tag_reg;
            notice_type_reg <= pick;
        end else if (link.notice_ready) begin
            notice_valid_reg <= 1'b0;
        end
    end

    assign link.notice_valid = notice_valid_reg;
    assign link.notice_inst_id = sbe_pkg::NOTICE_INST_ID;
    assign link.notice_chan_id = CHANNEL_ID;
    assign link.notice_ctl_tag = notice_tag_reg;
    assign link.notice_type = notice_type_reg;

    // ------------------------------------------------------------
    // status pulses
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            dropped_reg <= 1'b0;
            lost_reg <= 1'b0;
        end else begin
            dropped_reg <= cmd_drop;
            lost_reg <= lose;
        end
    end

    assign pt_enable = ~init_reg;
    assign in_initial = init_reg;
    assign cmd_dropped = dropped_reg;
    assign notice_lost = lost_reg;
endmodule
`default_nettype wire

// *** verilog/sbe_pkg.sv ***
package sbe_pkg;
    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int CLK_MHZ = 25;
    localparam int NORMAL_EXECUTION_INTERVAL_US = 50000;
    localparam int NORMAL_EXECUTION_CYCLES = NORMAL_EXECUTION_INTERVAL_US * CLK_MHZ;
    localparam int PROBE_INTERVAL_US = 100000;
    localparam int PROBE_CYCLES = PROBE_INTERVAL_US * CLK_MHZ;
    localparam int MAX_TRIES = 3;
    localparam logic [2:0] DRAIN_CYCLES = 3'h4;
    // ------------------------------------------------------------
    // header values
    // ------------------------------------------------------------
    localparam logic [7:0] NOTICE_INST_ID = 8'h00;
    localparam logic [7:0] HDR_REV = 8'h01;
    localparam logic [7:0] RSP_FLAG = 8'h80;
    localparam int NOTICE_KINDS = 3;
    // ------------------------------------------------------------
    // command types
    // ------------------------------------------------------------
    localparam logic [7:0] CMD_CLEAR_INIT = 8'h00;
    localparam logic [7:0] CMD_NOTICE_ENABLE = 8'h08;
    localparam logic [7:0] CMD_GET_STATUS = 8'h0a;
    localparam logic [7:0] CMD_OEM = 8'h50;
    // ------------------------------------------------------------
    // response and reason codes
    // ------------------------------------------------------------
    localparam logic [15:0] CODE_OK = 16'h0000;
    localparam logic [15:0] CODE_FAILED = 16'h0001;
    localparam logic [15:0] CODE_UNSUPPORTED = 16'h0003;
    localparam logic [15:0] CODE_TIMEOUT = 16'hffff;
    localparam logic [15:0] REASON_NONE = 16'h0000;
    localparam logic [15:0] REASON_INIT_REQ = 16'h0001;
    localparam logic [15:0] REASON_UNKNOWN_TYPE = 16'h7fff;
    // ------------------------------------------------------------
    // field positions and reset values
    // ------------------------------------------------------------
    localparam int ENABLE_LSB = 0;
    localparam int TAG_LSB = 24;
    localparam logic [7:0] TAG_RST = 8'h00;
    localparam logic INIT_RST = 1'b1;
endpackage

// *** verilog/sbe_link_if.sv ***
`timescale 1ns/1ps
`default_nettype none
interface sbe_link_if;
    logic cmd_valid;
    logic cmd_ready;
    logic [7:0] cmd_inst_id;
    logic [7:0] cmd_chan_id;
    logic [7:0] cmd_type;
    logic [7:0] cmd_rev;
    logic [31:0] cmd_data;
    logic cmd_fcs_ok;
    logic cmd_len_short;
    logic cmd_len_long;
    logic cmd_oem;
    logic cmd_csum_present;
    logic cmd_csum_ok;
    logic rsp_valid;
    logic rsp_ready;
    logic [7:0] rsp_inst_id;
    logic [7:0] rsp_chan_id;
    logic [7:0] rsp_type;
    logic [15:0] rsp_code;
    logic [15:0] rsp_reason;
    logic [31:0] rsp_data;
    logic notice_valid;
    logic notice_ready;
    logic [7:0] notice_inst_id;
    logic [7:0] notice_chan_id;
    logic [7:0] notice_ctl_tag;
    logic [7:0] notice_type;
    modport dev (
        input cmd_valid, cmd_inst_id, cmd_chan_id, cmd_type, cmd_rev, cmd_data,
        input cmd_fcs_ok, cmd_len_short, cmd_len_long, cmd_oem, cmd_csum_present,
        input cmd_csum_ok, rsp_ready, notice_ready,
        output cmd_ready, rsp_valid, rsp_inst_id, rsp_chan_id, rsp_type, rsp_code,
        output rsp_reason, rsp_data, notice_valid, notice_inst_id, notice_chan_id,
        output notice_ctl_tag, notice_type
    );
    modport mc (
        output cmd_valid, cmd_inst_id, cmd_chan_id, cmd_type, cmd_rev, cmd_data,
        output cmd_fcs_ok, cmd_len_short, cmd_len_long, cmd_oem, cmd_csum_present,
        output cmd_csum_ok, rsp_ready, notice_ready,
        input cmd_ready, rsp_valid, rsp_inst_id, rsp_chan_id, rsp_type, rsp_code,
        input rsp_reason, rsp_data, notice_valid, notice_inst_id, notice_chan_id,
        input notice_ctl_tag, notice_type
    );
endinterface
`default_nettype wire

// *** verilog/sbe_mc_end.sv ***
`timescale 1ns/1ps
`default_nettype none
module sbe_mc_end #(
    parameter logic [7:0] CHANNEL_ID = 8'h00,
    parameter int TIMEOUT_CYCLES = sbe_pkg::NORMAL_EXECUTION_CYCLES,
    parameter int PROBE_CYCLES = sbe_pkg::PROBE_CYCLES
) (
    input wire logic clk_sys,
    input wire logic reset,
    sbe_link_if.mc link,
    input wire logic req_valid,
    output logic req_ready,
    input wire logic [7:0] req_type,
    input wire logic [31:0] req_data,
    output logic done_valid,
    output logic done_ok,
    output logic [15:0] done_code,
    output logic [15:0] done_reason,
    output logic [31:0] done_data,
    output logic init_detected,
    output logic notice_seen,
    output logic [7:0] notice_seen_type,
    output logic [7:0] notice_seen_tag
);
    typedef enum logic [1:0] {MC_IDLE, MC_SEND, MC_WAIT} sbe_mc_state_t;
    sbe_mc_state_t state_reg;
    logic [7:0] inst_reg;
    logic [7:0] type_reg;
    logic [31:0] data_reg;
    logic [1:0] tries_reg;
    logic [31:0] timer_reg;
    logic [31:0] probe_reg;
    logic probing_reg;
    logic done_valid_reg, done_ok_reg, init_det_reg, seen_reg;
    logic [15:0] done_code_reg, done_reason_reg;
    logic [31:0] done_data_reg;
    logic [7:0] seen_type_reg, seen_tag_reg;

    // ------------------------------------------------------------
    // decode
    // ------------------------------------------------------------
    wire logic probe_due = probe_reg == 32'(PROBE_CYCLES - 1);
    wire logic start = (state_reg == MC_IDLE) & (probe_due | req_valid);
    wire logic [7:0] inst_inc = inst_reg + 8'h01;
    wire logic [7:0] inst_new = (inst_inc == 8'h00) ? 8'h01 : inst_inc;
    wire logic match = (state_reg == MC_WAIT) & link.rsp_valid
        & (link.rsp_inst_id == inst_reg);
    wire logic expired = (state_reg == MC_WAIT) & ~match
        & (timer_reg == 32'(TIMEOUT_CYCLES - 1));
    wire logic give_up = expired & (tries_reg == 2'(sbe_pkg::MAX_TRIES));
    wire logic rsp_ok = link.rsp_code == sbe_pkg::CODE_OK;
    wire logic saw_init = link.rsp_reason == sbe_pkg::REASON_INIT_REQ;

    assign req_ready = (state_reg == MC_IDLE) & ~probe_due;
    assign link.cmd_valid = state_reg == MC_SEND;
    assign link.cmd_inst_id = inst_reg;
    assign link.cmd_chan_id = CHANNEL_ID;
    assign link.cmd_type = type_reg;
    assign link.cmd_rev = sbe_pkg::HDR_REV;
    assign link.cmd_data = data_reg;
    assign link.cmd_fcs_ok = 1'b1;
    assign link.cmd_len_short = 1'b0;
    assign link.cmd_len_long = 1'b0;
    assign link.cmd_oem = type_reg == sbe_pkg::CMD_OEM;
    assign link.cmd_csum_present = 1'b1;
    assign link.cmd_csum_ok = 1'b1;
    assign link.rsp_ready = 1'b1;
    assign link.notice_ready = 1'b1;

    // ------------------------------------------------------------
    // command sequencer
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            state_reg <= MC_IDLE;
            inst_reg <= 8'h00;
            type_reg <= 8'h00;
            data_reg <= 32'h00000000;
            tries_reg <= 2'h0;
            timer_reg <= 32'h00000000;
            probing_reg <= 1'b0;
        end else begin
            case (state_reg)
                MC_IDLE: begin
                    if (start) begin
                        state_reg <= MC_SEND;
                        inst_reg <= inst_new;
                        tries_reg <= 2'h0;
                        probing_reg <= probe_due;
                        type_reg <= probe_due ? sbe_pkg::CMD_GET_STATUS : req_type;
                        data_reg <= probe_due ? 32'h00000000 : req_data;
                    end
                end
                MC_SEND: begin
                    if (link.cmd_ready) begin
                        state_reg <= MC_WAIT;
                        tries_reg <= tries_reg + 2'h1;
                        timer_reg <= 32'h00000000;
                    end
                end
                MC_WAIT: begin
                    timer_reg <= timer_reg + 32'h00000001;
                    if (match || give_up) begin
                        state_reg <= MC_IDLE;
                    end else if (expired) begin
                        state_reg <= MC_SEND;
                    end
                end
                default: begin
                    state_reg <= MC_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset || state_reg != MC_IDLE) begin
            probe_reg <= 32'h00000000;
        end else if (!probe_due) begin
            probe_reg <= probe_reg + 32'h00000001;
        end
    end

    // ------------------------------------------------------------
    // results
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            done_valid_reg <= 1'b0;
            done_ok_reg <= 1'b0;
            done_code_reg <= 16'h0000;
            done_reason_reg <= 16'h0000;
            done_data_reg <= 32'h00000000;
            init_det_reg <= 1'b0;
            seen_reg <= 1'b0;
            seen_type_reg <= 8'h00;
            seen_tag_reg <= 8'h00;
        end else begin
            done_valid_reg <= (match | give_up) & ~probing_reg;
            init_det_reg <= match & saw_init;
            seen_reg <= link.notice_valid;
            if (match) begin
                done_ok_reg <= rsp_ok;
                done_code_reg <= link.rsp_code;
                done_reason_reg <= link.rsp_reason;
                done_data_reg <= link.rsp_data;
            end else if (give_up) begin
                done_ok_reg <= 1'b0;
                done_code_reg <= sbe_pkg::CODE_TIMEOUT;
                done_reason_reg <= sbe_pkg::REASON_NONE;
                done_data_reg <= 32'h00000000;
            end
            if (link.notice_valid) begin
                seen_type_reg <= link.notice_type;
                seen_tag_reg <= link.notice_ctl_tag;
            end
        end
    end

    assign done_valid = done_valid_reg;
    assign done_ok = done_ok_reg;
    assign done_code = done_code_reg;
    assign done_reason = done_reason_reg;
    assign done_data = done_data_reg;
    assign init_detected = init_det_reg;
    assign notice_seen = seen_reg;
    assign notice_seen_type = seen_type_reg;
    assign notice_seen_tag = seen_tag_reg;
endmodule
`default_nettype wire

// *** verif/sbe_link_assertions.sv ***
`timescale 1ns/1ps
`default_nettype none
module sbe_link_chk #(
    parameter logic [7:0] CHANNEL_ID = 8'h00,
    parameter int TIMEOUT_CYCLES = 20
) (
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic cmd_valid,
    input wire logic [7:0] cmd_inst_id,
    input wire logic [7:0] cmd_type,
    input wire logic [7:0] cmd_rev,
    input wire logic rsp_valid,
    input wire logic [7:0] rsp_inst_id,
    input wire logic [7:0] rsp_type,
    input wire logic notice_valid,
    input wire logic [7:0] notice_inst_id,
    input wire logic [7:0] notice_chan_id
);
    // ----
    // cycles since the last command and whether it is unanswered
    // ----
    int cnt_reg;
    logic pend_reg;
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            cnt_reg <= 0;
            pend_reg <= 1'b0;
        end else begin
            cnt_reg <= cmd_valid ? 0 : cnt_reg + 1;
            pend_reg <= cmd_valid | (pend_reg & ~rsp_valid);
        end
    end
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (reset);
    a_notice_id_zero: assert property (notice_valid |-> notice_inst_id == 8'h00)
        else $error("notice instance id not zero");
    a_notice_own_chan: assert property (notice_valid |-> notice_chan_id == CHANNEL_ID)
        else $error("notice channel id wrong");
    a_rsp_inst_echo: assert property (cmd_valid |=>
        !rsp_valid || rsp_inst_id == $past(cmd_inst_id))
        else $error("response instance id not echoed");
    a_rsp_type_flag: assert property (cmd_valid |=>
        !rsp_valid || rsp_type == ($past(cmd_type) | 8'h80))
        else $error("response type wrong");
    a_rsp_after_cmd: assert property (rsp_valid |-> $past(cmd_valid))
        else $error("response without command");
    a_cmd_single: assert property (cmd_valid |=> !cmd_valid)
        else $error("command beat longer than one cycle");
    a_retry_wait: assert property (cmd_valid && pend_reg |-> cnt_reg >= TIMEOUT_CYCLES - 2)
        else $error("retry before timeout");
    a_cmd_rev_good: assert property (cmd_valid |-> cmd_rev == 8'h01)
        else $error("command revision wrong");
    cover property (cmd_valid && pend_reg);
    cover property (notice_valid);
    cover property (rsp_valid && rsp_type == 8'h80);
endmodule
`default_nettype wire

// *** verif/sideband_event_and_error_handling_tb.sv ***
`timescale 1ns/1ps
`default_nettype none
module sideband_event_and_error_handling_tb;
    logic clk_sys = 1'b0;
    logic reset = 1'b1;
    logic req_valid = 1'b0;
    logic [7:0] req_type = 8'h00;
    logic [31:0] req_data = 32'h0;
    logic [2:0] event_req = 3'h0;
    logic link_on = 1'b1;
    logic init_entry = 1'b0;
    logic req_ready, done_valid, notice_seen, pt_enable, in1, in2, drop2, lost1, init_det, done_ok;
    logic probe_hit;
    logic [15:0] done_code, done_reason;
    logic [31:0] done_data;
    logic [7:0] seen_type, seen_tag, tag;
    logic [2:0] en;
    int fails = 0;
    int comparisons = 0;
    int cycles = 0;
    sbe_link_if lk1();
    sbe_link_if lk2();
    sbe_mc_end #(.TIMEOUT_CYCLES(20), .PROBE_CYCLES(300)) sbe_mc_end_i (.clk_sys(clk_sys),
        .reset(reset), .link(lk1.mc), .req_valid(req_valid), .req_ready(req_ready),
        .req_type(req_type), .req_data(req_data), .done_valid(done_valid), .done_ok(done_ok),
        .done_code(done_code), .done_reason(done_reason), .done_data(done_data),
        .init_detected(init_det), .notice_seen(notice_seen), .notice_seen_type(seen_type),
        .notice_seen_tag(seen_tag));
    sbe_device_end sbe_device_end_i (.clk_sys(clk_sys), .reset(reset), .link(lk1.dev),
        .event_req(event_req), .sideband_link_active(link_on), .init_entry(init_entry),
        .pt_enable(pt_enable), .in_initial(in1), .cmd_dropped(), .notice_lost(lost1));
    sbe_device_end sbe_device_end_2_i (.clk_sys(clk_sys), .reset(reset), .link(lk2.dev),
        .event_req(event_req), .sideband_link_active(link_on), .init_entry(init_entry),
        .pt_enable(), .in_initial(in2), .cmd_dropped(drop2), .notice_lost());
    sbe_link_chk #(.CHANNEL_ID(8'h00), .TIMEOUT_CYCLES(20)) sbe_link_chk_i (.clk_sys(clk_sys),
        .reset(reset), .cmd_valid(lk1.cmd_valid), .cmd_inst_id(lk1.cmd_inst_id),
        .cmd_type(lk1.cmd_type), .cmd_rev(lk1.cmd_rev), .rsp_valid(lk1.rsp_valid),
        .rsp_inst_id(lk1.rsp_inst_id), .rsp_type(lk1.rsp_type),
        .notice_valid(lk1.notice_valid), .notice_inst_id(lk1.notice_inst_id),
        .notice_chan_id(lk1.notice_chan_id));
    initial forever #20 clk_sys = ~clk_sys;
    always @(posedge clk_sys) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            fails = fails + 1;
            end_sim();
        end
    end
    // ----
    // tasks
    // ----
    task automatic end_sim();
        $display("comparisons %0d fails %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            fails++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    function automatic logic [31:0] status_exp(input logic init, input logic [2:0] e);
        return {init, 1'b1, 27'h0, e};
    endfunction
    task automatic req(input logic [7:0] t, input logic [31:0] d);
        @(posedge clk_sys);
        req_valid <= 1'b1;
        req_type <= t;
        req_data <= d;
        do @(negedge clk_sys); while (req_ready !== 1'b1);
        @(posedge clk_sys);
        req_valid <= 1'b0;
        do @(negedge clk_sys); while (done_valid !== 1'b1);
    endtask
    task automatic watch(input logic exp, input logic [7:0] k);
        logic hit = 1'b0;
        repeat (3) begin
            @(negedge clk_sys);
            if (notice_seen === 1'b1) hit = 1'b1;
        end
        chk(hit, exp);
        if (exp) chk({seen_type, seen_tag}, {k, tag});
    endtask
    task automatic ev(input int k, input logic exp);
        @(posedge clk_sys);
        event_req <= 3'(1 << k);
        @(posedge clk_sys);
        event_req <= 3'h0;
        watch(exp, 8'(k));
    endtask
    task automatic set2(input int f, input logic [7:0] t, input logic [7:0] id);
        lk2.cmd_type <= t;
        lk2.cmd_inst_id <= id;
        lk2.cmd_fcs_ok <= f != 1;
        lk2.cmd_len_short <= f == 2;
        lk2.cmd_len_long <= f == 3 || f == 7;
        lk2.cmd_oem <= f == 7;
        lk2.cmd_csum_ok <= f != 4;
        lk2.cmd_chan_id <= f == 5 ? 8'h03 : 8'h00;
        lk2.cmd_rev <= f == 6 ? 8'h02 : 8'h01;
    endtask
    task automatic cmd2(input int f, input logic [7:0] t, input logic [7:0] id, input logic acc);
        @(posedge clk_sys);
        lk2.cmd_valid <= 1'b1;
        set2(f, t, id);
        @(posedge clk_sys);
        lk2.cmd_valid <= 1'b0;
        #1;
        chk(drop2, !acc);
        chk(lk2.rsp_inst_id === id, acc);
    endtask
    // ----
    // main sequence
    // ----
    initial begin
        void'($urandom(5));
        set2(0, 8'h00, 8'h00);
        lk2.cmd_valid <= 1'b0;
        lk2.cmd_data <= 32'h0;
        lk2.cmd_csum_present <= 1'b1;
        lk2.rsp_ready <= 1'b1;
        lk2.notice_ready <= 1'b1;
        tag = 8'($urandom);
        en = (3'($urandom) | 3'h1) & 3'h5;
        repeat (5) @(posedge clk_sys);
        reset <= 1'b0;
        req(sbe_pkg::CMD_CLEAR_INIT, 32'h0);
        chk({done_ok, done_code}, {1'b1, sbe_pkg::CODE_OK});
        chk({pt_enable, in1}, 2'b10);
        req(sbe_pkg::CMD_NOTICE_ENABLE, {tag, 21'h0, en});
        for (int k = 0; k < 3; k++) ev(k, en[k]);
        // all kinds at once: lowest enabled kind goes out, a second enabled one is lost
        @(posedge clk_sys);
        event_req <= 3'h7;
        @(posedge clk_sys);
        event_req <= 3'h0;
        @(negedge clk_sys);
        chk(lost1, en[2]);
        watch(1'b1, 8'h00);
        $display("test 1 done");
        @(posedge clk_sys);
        link_on <= 1'b0;
        ev(0, 1'b0);
        @(posedge clk_sys);
        link_on <= 1'b1;
        watch(1'b0, 8'h00);
        $display("test 2 done");
        req(sbe_pkg::CMD_GET_STATUS, 32'h0);
        chk(done_data, status_exp(1'b0, en));
        req(8'h33, 32'h0);
        chk({done_code, done_reason},
            {sbe_pkg::CODE_UNSUPPORTED, sbe_pkg::REASON_UNKNOWN_TYPE});
        chk(done_ok, 1'b0);
        $display("test 3 done");
        @(posedge clk_sys);
        init_entry <= 1'b1;
        @(posedge clk_sys);
        init_entry <= 1'b0;
        req(sbe_pkg::CMD_GET_STATUS, 32'h0);
        chk({done_code, done_reason}, {sbe_pkg::CODE_FAILED, sbe_pkg::REASON_INIT_REQ});
        chk({pt_enable, in1}, 2'b01);
        ev(0, 1'b0);
        $display("test 4 done");
        for (int f = 0; f < 8; f++)
            cmd2(f, f == 7 ? sbe_pkg::CMD_OEM : sbe_pkg::CMD_GET_STATUS, 8'(f + 1),
                f == 0 || f == 7);
        $display("test 5 done");
        cmd2(0, sbe_pkg::CMD_GET_STATUS, 8'h2a, 1'b1);
        cmd2(0, sbe_pkg::CMD_CLEAR_INIT, 8'h2a, 1'b1);
        chk({lk2.rsp_type, 7'h0, in2}, {8'h8a, 8'h01});
        @(posedge clk_sys);
        lk2.rsp_ready <= 1'b0;
        cmd2(0, sbe_pkg::CMD_GET_STATUS, 8'h2b, 1'b1);
        cmd2(0, sbe_pkg::CMD_GET_STATUS, 8'h2c, 1'b0);
        $display("test 6 done");
        // the idle controller probes on its own; the device is still initial
        probe_hit = 1'b0;
        repeat (310) begin
            @(negedge clk_sys);
            if (init_det === 1'b1) probe_hit = 1'b1;
        end
        chk(probe_hit, 1'b1);
        $display("test 7 done");
        end_sim();
    end
endmodule
`default_nettype wire
